// File: design/mcg_clock_gen.sv
// Clock generation: source select, RC and watchdog oscillators, CPU clock divider,
// peripheral clock, clock output and the tune/divider/aux registers on APB.
// Assumes one 50 MHz core clock; oscillator edges appear as one-cycle ticks of it.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "mcg_regs.svh"
module mcg_clock_gen (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic por_reset,
  input wire logic [5:0] factory_trim,
  input wire logic [2:0] osc_config,
  input wire logic rtc_on_crystal,
  input wire logic crystal_input_pin,
  input wire logic power_down,
  input wire logic wake_request,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic cpu_tick,
  output logic machine_cycle,
  output logic peripheral_tick,
  output logic cpu_running,
  output logic low_power_clock_select,
  output logic [5:0] rc_trim,
  output logic [1:0] crystal_range,
  output logic crystal_output_clock_pin_o,
  output logic crystal_output_clock_pin_oe
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic [5:0] trim_ff, nxt_trim; // RC trim field
  logic clock_output_enable_ff, nxt_clock_output_enable; // Clock output enable
  logic [7:0] div_ff, nxt_div; // Divider value seen by software
  logic lp_ff, nxt_lp; // Low-power clock select
  mcg_pkg::mcg_src_t src_ff, nxt_src; // Latched source choice
  logic [1:0] range_ff, nxt_range; // Crystal amplifier range, off for other sources
  logic xin_s1_ff, xin_s2_ff, xin_s3_ff; // Crystal input synchroniser and edge history
  logic [15:0] nco_ff, nxt_nco; // Shared RC/watchdog phase accumulator
  logic [16:0] nco_sum;
  logic [15:0] nco_inc;
  logic [7:0] div_act_ff, nxt_div_act; // Divider value in use
  logic [8:0] cnt_ff, nxt_cnt, term; // Oscillator ticks within a CPU cycle and its last count
  logic cpu_tick_ff, nxt_cpu_tick, mcyc_ff, nxt_mcyc, ptick_ff, nxt_ptick;
  logic phase_ff, nxt_phase; // Half of the machine cycle
  logic pclk_ff, nxt_pclk; // Peripheral clock level, CPU/2
  logic xout_ff, nxt_xout, xoe_ff, nxt_xoe;
  mcg_pkg::mcg_state_t state_ff, nxt_state;
  logic [11:0] hold_ff, nxt_hold; // Hold-off counter
  logic running_ff, nxt_running; // CPU clock allowed; a flop so the output needs no decode
  logic is_crystal, apb_acc, osc_tick; // Tick pulses once per oscillator clock cycle
  logic [9:0] idx;
  assign idx = paddr[11:2];
  assign apb_acc = psel && penable && pready_ff;
  // Only crystal sources switch the amplifier on, so its range tells them apart
  assign is_crystal = (range_ff != `MCG_RANGE_OFF);
  // ****************************************************************
  // APB slave and registers
  // ****************************************************************
  // One wait state: pready rises the cycle after the access phase starts,
  // so read data and the error flag always come from flip-flops
  always_comb begin
    nxt_pready = psel && penable && !pready_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    nxt_trim = trim_ff;
    nxt_clock_output_enable = clock_output_enable_ff;
    nxt_div = div_ff;
    nxt_lp = lp_ff;
    if (nxt_pready) begin
      nxt_prdata = 32'h0000_0000;
      unique case (idx)
        `MCG_TUNE_IDX: begin
          nxt_prdata[`MCG_TRIM_MSB:`MCG_TRIM_LSB] = trim_ff;
          nxt_prdata[`MCG_CLOCK_OUTPUT_ENABLE_BIT] = clock_output_enable_ff;
        end
        `MCG_DIV_IDX: nxt_prdata[`MCG_DIV_MSB:0] = div_ff;
        `MCG_AUX_IDX: nxt_prdata[`MCG_LP_BIT] = lp_ff;
        `MCG_STAT_IDX: begin
          nxt_prdata[2:0] = 3'(src_ff);
          nxt_prdata[`MCG_STAT_RUN_BIT] = running_ff;
          nxt_prdata[`MCG_STAT_CLKOUT_BIT] = xoe_ff;
        end
        default: nxt_pslverr = 1'b1;       // Unmapped address answers with an error
      endcase
    end
    // Writes land only on the completing edge
    if (apb_acc && pwrite) begin
      unique case (idx)
        `MCG_TUNE_IDX: begin
          nxt_trim = pwdata[`MCG_TRIM_MSB:`MCG_TRIM_LSB];
          nxt_clock_output_enable = pwdata[`MCG_CLOCK_OUTPUT_ENABLE_BIT];
        end
        `MCG_DIV_IDX: nxt_div = pwdata[`MCG_DIV_MSB:0];
        `MCG_AUX_IDX: nxt_lp = pwdata[`MCG_LP_BIT];
        default: ;
      endcase
    end
  end
  // Register the bus and software-visible state
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
      div_ff <= `MCG_DIV_RST;
      lp_ff <= 1'b0;
      if (por_reset) begin
        trim_ff <= factory_trim;
        clock_output_enable_ff <= 1'b0;
      end
    end else if (ce) begin
      pready_ff <= nxt_pready;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
      trim_ff <= nxt_trim;
      clock_output_enable_ff <= nxt_clock_output_enable;
      div_ff <= nxt_div;
      lp_ff <= nxt_lp;
    end
  end
  // ****************************************************************
  // Source selection from flash configuration
  // ****************************************************************
  // Decoded only during reset, so no runtime write can switch the source
  always_comb begin
    nxt_src = src_ff;
    nxt_range = range_ff;
    if (!rst_b) begin
      unique case (osc_config)
        `MCG_CFG_XLOW: begin
          nxt_src = mcg_pkg::mcg_src_xlow;
          nxt_range = `MCG_RANGE_LOW;
        end
        `MCG_CFG_XMED: begin
          nxt_src = mcg_pkg::mcg_src_xmed;
          nxt_range = `MCG_RANGE_MED;
        end
        `MCG_CFG_XHIGH: begin
          nxt_src = mcg_pkg::mcg_src_xhigh;
          nxt_range = `MCG_RANGE_HIGH;
        end
        `MCG_CFG_EXT: begin
          nxt_src = mcg_pkg::mcg_src_ext;
          nxt_range = `MCG_RANGE_OFF;
        end
        `MCG_CFG_WDOG: begin
          nxt_src = mcg_pkg::mcg_src_wdog;
          nxt_range = `MCG_RANGE_OFF;
        end
        default: begin
          // Unused codes fall back to the RC oscillator
          nxt_src = mcg_pkg::mcg_src_rc;
          nxt_range = `MCG_RANGE_OFF;
        end
      endcase
    end
  end
  // Latch the choice while reset is held
  always_ff @(posedge core_clk) begin
    src_ff <= nxt_src;
    range_ff <= nxt_range;
  end
  // ****************************************************************
  // Oscillator ticks
  // ****************************************************************
  // RC and watchdog oscillators are phase accumulators; trim steps the RC rate
  always_comb begin
    if (src_ff == mcg_pkg::mcg_src_wdog) begin
      nco_inc = 16'(`MCG_WDOG_INC);
    end else begin
      nco_inc = 16'(`MCG_RC_INC_BASE) + 16'(($signed({1'b0, trim_ff}) - $signed({1'b0, `MCG_TRIM_MID})) *
                $signed({1'b0, `MCG_RC_INC_STEP}));
    end
    nco_sum = {1'b0, nco_ff} + {1'b0, nco_inc};
    nxt_nco = nco_sum[15:0];
    unique case (src_ff)
      mcg_pkg::mcg_src_rc, mcg_pkg::mcg_src_wdog: osc_tick = nco_sum[16];
      default: osc_tick = xin_s2_ff && !xin_s3_ff;
    endcase
  end
  // Crystal input passes two flip-flops; the second and a third one for edge history are looked at
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      xin_s1_ff <= 1'b0;
      xin_s2_ff <= 1'b0;
      xin_s3_ff <= 1'b0;
      nco_ff <= 16'h0000;
    end else if (ce) begin
      xin_s1_ff <= crystal_input_pin;
      xin_s2_ff <= xin_s1_ff;
      xin_s3_ff <= xin_s2_ff;
      nco_ff <= nxt_nco;
    end
  end
  // ****************************************************************
  // Wake-up hold-off
  // ****************************************************************
  // Crystal sources wait 992 oscillator cycles then the fixed extra time;
  // other sources start at once. Power-down stops the CPU clock.
  always_comb begin
    nxt_state = state_ff;
    nxt_hold = hold_ff;
    unique case (state_ff)
      mcg_pkg::mcg_st_hold_osc: begin
        if (!is_crystal) begin
          nxt_state = mcg_pkg::mcg_st_run;
        end else if (osc_tick) begin
          if (hold_ff == 12'(`MCG_XTAL_OSC_CYC) - 12'h001) begin
            nxt_state = mcg_pkg::mcg_st_hold_time;
            nxt_hold = 12'h000;
          end else begin
            nxt_hold = hold_ff + 12'h001;
          end
        end
      end
      mcg_pkg::mcg_st_hold_time: begin
        if (hold_ff == 12'(`MCG_WAKE_EXTRA_CYC) - 12'h001) begin
          nxt_state = mcg_pkg::mcg_st_run;
        end else begin
          nxt_hold = hold_ff + 12'h001;
        end
      end
      mcg_pkg::mcg_st_run: begin
        if (power_down) begin
          nxt_state = mcg_pkg::mcg_st_stop;
        end
      end
      mcg_pkg::mcg_st_stop: begin
        if (wake_request) begin
          nxt_state = mcg_pkg::mcg_st_hold_osc;
          nxt_hold = 12'h000;
        end
      end
    endcase
    nxt_running = (nxt_state == mcg_pkg::mcg_st_run);
  end
  // Register the hold-off state
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_ff <= mcg_pkg::mcg_st_hold_osc;
      hold_ff <= 12'h000;
      running_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      hold_ff <= nxt_hold;
      running_ff <= nxt_running;
    end
  end
  // ****************************************************************
  // CPU clock divider and derived clocks
  // ****************************************************************
  // A new divider value is taken only at the end of a CPU cycle, so no
  // short or stretched cycle can appear when software changes it
  always_comb begin
    term = {div_act_ff, 1'b0} - 9'h001;
    nxt_div_act = div_act_ff;
    nxt_cnt = cnt_ff;
    nxt_cpu_tick = 1'b0;
    if (running_ff && osc_tick) begin
      if (div_act_ff == 8'h00 || cnt_ff == term) begin
        nxt_cpu_tick = 1'b1;
        nxt_cnt = 9'h000;
        nxt_div_act = div_ff;
      end else begin
        nxt_cnt = cnt_ff + 9'h001;
      end
    end
    nxt_phase = phase_ff ^ cpu_tick_ff;
    nxt_mcyc = cpu_tick_ff && phase_ff;
    nxt_ptick = cpu_tick_ff && phase_ff;
    nxt_pclk = pclk_ff ^ cpu_tick_ff;
    // Clock output only while the crystal is idle for both CPU and RTC
    nxt_xoe = clock_output_enable_ff && !is_crystal && !rtc_on_crystal;
    nxt_xout = nxt_xoe && nxt_pclk;
  end
  // Register divider and clock outputs
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      div_act_ff <= `MCG_DIV_RST;
      cnt_ff <= 9'h000;
      cpu_tick_ff <= 1'b0;
      phase_ff <= 1'b0;
      mcyc_ff <= 1'b0;
      ptick_ff <= 1'b0;
      pclk_ff <= 1'b0;
      xoe_ff <= 1'b0;
      xout_ff <= 1'b0;
    end else if (ce) begin
      div_act_ff <= nxt_div_act;
      cnt_ff <= nxt_cnt;
      cpu_tick_ff <= nxt_cpu_tick;
      phase_ff <= nxt_phase;
      mcyc_ff <= nxt_mcyc;
      ptick_ff <= nxt_ptick;
      pclk_ff <= nxt_pclk;
      xoe_ff <= nxt_xoe;
      xout_ff <= nxt_xout;
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign cpu_tick = cpu_tick_ff;
  assign machine_cycle = mcyc_ff;
  assign peripheral_tick = ptick_ff;
  assign cpu_running = running_ff;
  assign low_power_clock_select = lp_ff;
  assign rc_trim = trim_ff;
  assign crystal_range = range_ff;
  assign crystal_output_clock_pin_o = xout_ff;
  assign crystal_output_clock_pin_oe = xoe_ff;
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_enter_extra;
    ce && state_ff == mcg_pkg::mcg_st_hold_osc && nxt_state == mcg_pkg::mcg_st_hold_time;
  endsequence
  sequence s_quiet_cpu;
    (!cpu_tick_ff)[*8];
  endsequence
  AST_MC_TWO: assert property (ce && cpu_tick_ff && phase_ff |=> mcyc_ff)
    else $error("machine cycle missing after second cpu cycle");
  AST_PCLK_HALF: assert property (ce && cpu_tick_ff |=> pclk_ff != $past(pclk_ff))
    else $error("peripheral clock did not toggle on cpu cycle");
  AST_DIV_BYPASS: assert property (ce && running_ff && osc_tick && div_act_ff == 8'h00 |=> cpu_tick_ff)
    else $error("undivided cpu clock missed an oscillator cycle");
  AST_DIV_RANGE: assert property (div_act_ff == 8'h00 || cnt_ff <= term)
    else $error("divider count passed its terminal value");
  AST_LP_RESET: assert property (disable iff (1'b0) !rst_b |=> !lp_ff)
    else $error("low-power select survived reset");
  AST_TRIM_KEEP: assert property (disable iff (1'b0) !rst_b && !por_reset |=> trim_ff == $past(trim_ff))
    else $error("trim changed on a non power-on reset");
  AST_CLKOUT_GATE: assert property (xoe_ff |-> $past(clock_output_enable_ff && !is_crystal && !rtc_on_crystal))
    else $error("clock output driven while crystal in use");
  AST_CLKOUT_RATE: assert property (xoe_ff |-> xout_ff == pclk_ff)
    else $error("clock output not at half cpu rate");
  AST_XTAL_HOLD: assert property (s_enter_extra |=> s_quiet_cpu)
    else $error("cpu clock ran during crystal hold-off");
  AST_TUNE_READ: assert property (ce && nxt_pready && idx == `MCG_TUNE_IDX |=> prdata_ff[5:0] == $past(trim_ff))
    else $error("tune register read wrong trim");
endmodule

// File: design/mcg_pkg.sv
// Types shared by the clock generator: oscillator sources and hold-off states.
// Assumes nothing of its surroundings.
package mcg_pkg;

  // Oscillator clock source picked by flash configuration
  typedef enum logic [2:0] {
    mcg_src_xlow,
    mcg_src_xmed,
    mcg_src_xhigh,
    mcg_src_ext,
    mcg_src_rc,
    mcg_src_wdog
  } mcg_src_t;

  // Start-up and power state of the CPU clock
  typedef enum logic [1:0] {
    mcg_st_hold_osc,
    mcg_st_hold_time,
    mcg_st_run,
    mcg_st_stop
  } mcg_state_t;

endpackage

// File: design/mcg_regs.svh
// Register map, field positions, reset values and timing counts of the clock generator.
// Assumes inclusion by bare name from the clock generator module only.
`ifndef MCG_REGS_SVH
`define MCG_REGS_SVH

// Register indices; byte address is four times the index
`define MCG_TUNE_IDX 10'h096
`define MCG_DIV_IDX 10'h095
`define MCG_STAT_IDX 10'h097
`define MCG_AUX_IDX 10'h0A2

// Field positions
`define MCG_TRIM_MSB 5
`define MCG_TRIM_LSB 0
`define MCG_CLOCK_OUTPUT_ENABLE_BIT 6
`define MCG_LP_BIT 7
`define MCG_DIV_MSB 7
`define MCG_STAT_RUN_BIT 3
`define MCG_STAT_CLKOUT_BIT 4

// Divider reset value and trim midpoint
`define MCG_DIV_RST 8'h00
`define MCG_TRIM_MID 6'h20

// Flash configuration codes for the oscillator source
`define MCG_CFG_XLOW 3'h0
`define MCG_CFG_XMED 3'h1
`define MCG_CFG_XHIGH 3'h2
`define MCG_CFG_EXT 3'h3
`define MCG_CFG_RC 3'h4
`define MCG_CFG_WDOG 3'h5

// Crystal amplifier range codes
`define MCG_RANGE_OFF 2'h0
`define MCG_RANGE_LOW 2'h1
`define MCG_RANGE_MED 2'h2
`define MCG_RANGE_HIGH 2'h3

// Frequencies in kHz and the core clock rate
`define MCG_CORE_CLK_MHZ 50
`define MCG_RC_NOMINAL_KHZ 7373
`define MCG_WDOG_NOMINAL_KHZ 400
`define MCG_NCO_FULL 65536
`define MCG_RC_INC_BASE ((`MCG_RC_NOMINAL_KHZ * `MCG_NCO_FULL) / (`MCG_CORE_CLK_MHZ * 1000))
`define MCG_WDOG_INC ((`MCG_WDOG_NOMINAL_KHZ * `MCG_NCO_FULL) / (`MCG_CORE_CLK_MHZ * 1000))
`define MCG_RC_INC_STEP 16'h0018

// Crystal wake-up hold-off
`define MCG_XTAL_OSC_CYC 10'h3E0
`define MCG_WAKE_EXTRA_US 60
`define MCG_WAKE_EXTRA_CYC ((`MCG_WAKE_EXTRA_US) * (`MCG_CORE_CLK_MHZ))

`endif

// File: sim/mcg_clock_gen_tb_top.sv
// Self-checking bench for the clock generator: APB tasks, external source model.
// Assumes the design answers APB with one wait state and takes the source only in reset.
`timescale 1ns/1ps
module mcg_clock_gen_tb_top;
  // ************************************
  // Signals
  // ************************************
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic por_reset = 1'b1;
  logic [5:0] factory_trim = 6'h2A;
  logic [2:0] osc_config = 3'h3;
  logic rtc_on_crystal = 1'b0;
  logic power_down = 1'b0;
  logic wake_request = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, cpu_tick, machine_cycle, peripheral_tick, cpu_running, lp_sel, clk_o, clk_oe, xin, err;
  logic [5:0] rc_trim;
  logic [1:0] crystal_range;
  logic osc_run = 1'b0;
  int bad_count = 0;
  int samples_checked = 0;
  int c, c2;
  logic [7:0] divs [4] = '{8'h00, 8'h01, 8'h03, 8'hFF};

  // 50 MHz core clock
  always #10 core_clk = ~core_clk;

  // Source period is 200 ns, ten core cycles per oscillator cycle
  mcg_ext_osc mcg_ext_osc_i (.run(osc_run), .half_ns(16'h0064), .pin(xin));

  mcg_clock_gen mcg_clock_gen_i (
    .core_clk(core_clk), .rst_b(rst_b), .ce(1'b1), .por_reset(por_reset), .factory_trim(factory_trim),
    .osc_config(osc_config), .rtc_on_crystal(rtc_on_crystal), .crystal_input_pin(xin),
    .power_down(power_down), .wake_request(wake_request), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_tick(cpu_tick), .machine_cycle(machine_cycle), .peripheral_tick(peripheral_tick),
    .cpu_running(cpu_running), .low_power_clock_select(lp_sel), .rc_trim(rc_trim),
    .crystal_range(crystal_range), .crystal_output_clock_pin_o(clk_o), .crystal_output_clock_pin_oe(clk_oe));

  // ************************************
  // Tasks
  // ************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One APB transfer; values read right after an edge are those sampled at it
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check(n, 2, "apb wait states");
  endtask

  task automatic do_reset(input logic por, input logic [2:0] cfg);
    @(posedge core_clk);
    rst_b <= 1'b0;
    por_reset <= por;
    osc_config <= cfg;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    por_reset <= 1'b0;
    @(posedge core_clk);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return cpu_tick;
      1: return peripheral_tick;
      default: return machine_cycle;
    endcase
  endfunction

  // Core cycles from one pulse (s 0..2) or output toggle (s 3) to the k-th one after it
  task automatic gap(input int s, input int k, output int cyc);
    int seen, t;
    logic last;
    seen = -1;
    cyc = 0;
    t = 0;
    last = clk_o;
    while (seen < k && t < 20000) begin
      @(posedge core_clk);
      t++;
      if (seen >= 0) cyc++;
      if ((s == 3) ? (clk_o !== last) : (pick(s) === 1'b1)) seen++;
      last = clk_o;
    end
    if (t >= 20000) check(1'b0, 1'b1, "no pulses");
  endtask

  // Cycles until the CPU clock runs, bounded
  task automatic hold(output int cyc);
    cyc = 0;
    while (cpu_running !== 1'b1 && cyc < 20000) begin
      @(posedge core_clk);
      cyc++;
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog: the whole run needs about 50k cycles
  initial begin
    repeat (90000) @(posedge core_clk);
    bad_count++;
    give_verdict();
  end

  // ************************************
  // Tests
  // ************************************
  initial begin
    do_reset(1'b1, 3'h3);
    check(rc_trim, 6'h2A, "trim after power-on");
    check(lp_sel, 1'b0, "low power after reset");
    apb(1'b0, 10'h096, 32'h0);
    check(rd[6:0], 7'h2A, "tune readback");
    apb(1'b0, 10'h095, 32'h0);
    check(rd, 32'h00000000, "divider reset");
    apb(1'b0, 10'h001, 32'h0);
    check(err, 1'b1, "unmapped refused");
    $display("test registers done");
    // External source: divider 0 passes through, N gives 2N
    osc_run <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 10'h095, {24'h0, divs[i]});
      gap(0, 1, c);
      gap(0, 2, c);
      check(c, (divs[i] == 8'h00) ? 20 : 40 * divs[i], "cpu period");
    end
    apb(1'b1, 10'h095, 32'h00000001);
    gap(0, 1, c);
    gap(1, 2, c);
    check(c, 80, "peripheral period");
    gap(2, 2, c);
    check(c, 80, "machine cycle");
    apb(1'b1, 10'h096, 32'h0000006A);
    repeat (3) @(posedge core_clk);
    check(clk_oe, 1'b1, "clock out enabled");
    gap(3, 2, c);
    check(c, 40, "clock out half rate");
    rtc_on_crystal <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(clk_oe, 1'b0, "rtc blocks clock out");
    rtc_on_crystal <= 1'b0;
    $display("test divider done");
    // Low power bit, trim writes and a warm reset
    apb(1'b1, 10'h0A2, 32'h00000080);
    @(posedge core_clk);
    check(lp_sel, 1'b1, "low power set");
    apb(1'b1, 10'h096, 32'h00000055);
    @(posedge core_clk);
    check(rc_trim, 6'h15, "trim written");
    for (int i = 0; i < 6; i++) begin
      do_reset(1'b0, i[2:0]);
      check(crystal_range, (i < 3) ? i + 1 : 0, "range");
      apb(1'b0, 10'h097, 32'h0);
      check(rd[2:0], i[2:0], "source");
    end
    do_reset(1'b0, 3'h2);
    check(lp_sel, 1'b0, "low power cleared");
    check(rc_trim, 6'h15, "trim kept");
    check(clk_oe, 1'b0, "crystal blocks clock out");
    hold(c);
    check(c >= 12900 && c <= 14960, 1'b1, "reset hold-off");
    power_down <= 1'b1;
    repeat (4) @(posedge core_clk);
    check(cpu_running, 1'b0, "stopped");
    power_down <= 1'b0;
    wake_request <= 1'b1;
    @(posedge core_clk);
    wake_request <= 1'b0;
    hold(c);
    check(c >= 12900 && c <= 14960, 1'b1, "wake hold-off");
    $display("test crystal done");
    // RC and watchdog sources
    do_reset(1'b0, 3'h4);
    apb(1'b1, 10'h096, 32'h00000020);
    repeat (2) @(posedge core_clk);
    check(clk_oe, 1'b0, "clock out disabled by software");
    apb(1'b1, 10'h097, 32'h00000000);
    apb(1'b0, 10'h097, 32'h0);
    check(rd[2:0], 3'h4, "source not writable");
    gap(0, 100, c);
    check(c >= 670 && c <= 686, 1'b1, "rc nominal");
    apb(1'b1, 10'h096, 32'h0000003F);
    gap(0, 1, c2);
    gap(0, 100, c2);
    check(c2 < c, 1'b1, "rc retuned");
    do_reset(1'b0, 3'h5);
    gap(0, 8, c);
    check(c >= 990 && c <= 1010, 1'b1, "watchdog source");
    $display("test sources done");
    give_verdict();
  end
endmodule

// File: sim/mcg_ext_osc.sv
// External clock source model that drives the crystal input pin.
// Assumes the bench sets the half period and starts or stops it with run.
`timescale 1ns/1ps
module mcg_ext_osc (
  input wire logic run,
  input wire logic [15:0] half_ns,
  output logic pin
);
  // A stopped source rests low, so 0 Hz is a legal rate
  // Start is offset by 7 ns so edges never meet the core clock edge
  initial begin
    pin = 1'b0;
    forever begin
      if (run) begin
        #(half_ns) pin = ~pin;
      end else begin
        pin = 1'b0;
        @(posedge run);
        #7;
      end
    end
  end
endmodule
